// >>> src/rbt_transceiver.sv
// Purpose: Three-channel registered bus transceiver with cutoff bus outputs.
// Assumes: mclk at 125 MHz; both device clocks are slow pins sampled on mclk.
// Notes:   A rising edge of either device clock is one register update.
//          Controls are taken as level inputs held steady around that edge.
//
// Overview of operation
// - Three channels, each with one transmit and one receive register bit.
// - Transmit register holds or loads A/B data per transmit_load_enable.
// - Both bus_drive_enable inputs low, once clocked in, cut off the bus.
// - A low bus output turns its driver off, leaving the line undriven.
// - Receive registers capture bus lines gated by receive_gate_n, low active.
// - All registers update on rising edge of either clock input, or both.
`default_nettype none
module rbt_transceiver (
  // System clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Device clock pins.
  input  wire logic                 first_clock_input,
  input  wire logic                 second_clock_input,
  // Transmit controls and data.
  input  wire logic                 transmit_load_enable,
  input  wire logic                 data_select_b,
  input  wire rbt_pkg::rbt_data_in_t data_in,
  input  wire logic [1:0]           bus_drive_enable,
  // Receive control.
  input  wire logic                 receive_gate_n,
  // Bus lines: level seen on the wire, and this device's drive.
  input  wire rbt_pkg::rbt_ch_t     bus_line_i,
  output var  rbt_pkg::rbt_bus_out_t bus_out,
  // Receive outputs.
  output var  rbt_pkg::rbt_ch_t     receive_output
);

  // Three-stage synchronisers for the two clock pins.
  // Stage one may be metastable; only stages two and three feed logic.
  logic [rbt_pkg::SYNC_LEN-1:0] c1_sync_q, c1_sync_d;
  logic [rbt_pkg::SYNC_LEN-1:0] c2_sync_q, c2_sync_d;

  always_comb begin
    c1_sync_d = {c1_sync_q[rbt_pkg::SYNC_LEN-2:0], first_clock_input};
    c2_sync_d = {c2_sync_q[rbt_pkg::SYNC_LEN-2:0], second_clock_input};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c1_sync_q <= '0;
      c2_sync_q <= '0;
    end else begin
      c1_sync_q <= c1_sync_d;
      c2_sync_q <= c2_sync_d;
    end
  end

  // A level counts once stages two and three agree; track the filtered level.
  logic [1:0] clk_lvl_q, clk_lvl_d;
  logic       rise1, rise2, tick;

  // Returns the level that stages two and three agree on. While they differ
  // the pin is mid-transition, so the last agreed level stands.
  function automatic logic agreed(input logic [rbt_pkg::SYNC_LEN-1:0] s,
                                  input logic prev);
    agreed = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  always_comb begin
    clk_lvl_d[0] = agreed(c1_sync_q, clk_lvl_q[0]);
    clk_lvl_d[1] = agreed(c2_sync_q, clk_lvl_q[1]);
    rise1 = clk_lvl_d[0] & ~clk_lvl_q[0];
    rise2 = clk_lvl_d[1] & ~clk_lvl_q[1];
    // Both pins rising together still give a single update.
    tick  = rise1 | rise2;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      clk_lvl_q <= rbt_pkg::CLK_ZERO;
    end else begin
      clk_lvl_q <= clk_lvl_d;
    end
  end

  // Data and control pins are taken to be stable around device clock edges and are used
  // directly; only the bus lines are sampled by the same three-stage scheme as a single bus word.
  // The equal depth lines the bus sample up with the clock path, so the
  // receive register sees the line as it stood at the pin edge.
  logic [rbt_pkg::NUM_CH-1:0] bus_s1_q, bus_s2_q, bus_s3_q;
  logic [rbt_pkg::NUM_CH-1:0] bus_s1_d, bus_s2_d, bus_s3_d;

  always_comb begin
    bus_s1_d = bus_line_i;
    bus_s2_d = bus_s1_q;
    bus_s3_d = bus_s2_q;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_s1_q <= rbt_pkg::CH_ZERO;
      bus_s2_q <= rbt_pkg::CH_ZERO;
      bus_s3_q <= rbt_pkg::CH_ZERO;
    end else begin
      bus_s1_q <= bus_s1_d;
      bus_s2_q <= bus_s2_d;
      bus_s3_q <= bus_s3_d;
    end
  end

  // Device registers. One update strobe serves all three, so the transmit,
  // receive and enable bits update on the same tick, transmit only with its load and receive only with its gate.
  rbt_pkg::rbt_ch_t tx_q, tx_d, rx_q, rx_d;
  logic             en_q, en_d;

  always_comb begin
    tx_d = tx_q;
    rx_d = rx_q;
    en_d = en_q;
    if (tick) begin
      if (transmit_load_enable) begin
        tx_d = data_select_b ? data_in.b : data_in.a;
      end
      // Both enables low clears the flop; either one high sets it.
      en_d = |bus_drive_enable;
      if (!receive_gate_n) begin
        // Delayed sample: the level before this update, not the new drive.
        rx_d = bus_s3_q;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Reset only gives the flops a known start; the device has none.
      tx_q <= rbt_pkg::CH_ZERO;
      rx_q <= rbt_pkg::CH_ZERO;
      en_q <= 1'b0;
    end else begin
      tx_q <= tx_d;
      rx_q <= rx_d;
      en_q <= en_d;
    end
  end

  // A low output is cutoff: the driver releases the line.
  // The enable follows the level, so a channel drives only when high.
  always_comb begin
    bus_out.o  = tx_q & {rbt_pkg::NUM_CH{en_q}};
    bus_out.oe = bus_out.o;
    receive_output = rx_q;
  end

  // Rule checks, all sampled on the system clock.
  cut_off_a: assert property (@(posedge mclk) disable iff (rst)
    !en_q |-> bus_out.oe == rbt_pkg::CH_ZERO)
    else $error("bus driven while disabled");

  en_capture_a: assert property (@(posedge mclk) disable iff (rst)
    tick && bus_drive_enable == rbt_pkg::EN_ZERO |=> !en_q)
    else $error("enable not cleared");

  low_release_a: assert property (@(posedge mclk) disable iff (rst)
    (bus_out.oe & ~bus_out.o) == rbt_pkg::CH_ZERO)
    else $error("low level driven");

  tx_load_a: assert property (@(posedge mclk) disable iff (rst)
    tick && transmit_load_enable |=>
      tx_q == ($past(data_select_b) ? $past(data_in.b) : $past(data_in.a)))
    else $error("transmit load wrong");

  tx_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !(tick && transmit_load_enable) |=> $stable(tx_q))
    else $error("transmit changed without load");

  rx_capture_a: assert property (@(posedge mclk) disable iff (rst)
    tick && !receive_gate_n |=> receive_output == $past(bus_s3_q))
    else $error("receive capture wrong");

  rx_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !(tick && !receive_gate_n) |=> $stable(receive_output))
    else $error("receive changed while gated");

  no_tick_a: assert property (@(posedge mclk) disable iff (rst)
    !tick |=> $stable(en_q) && $stable(tx_q) && $stable(rx_q))
    else $error("update without clock edge");

  either_clk_a: assert property (@(posedge mclk) disable iff (rst)
    rise1 || rise2 |-> tick)
    else $error("edge missed");

  tick_source_a: assert property (@(posedge mclk) disable iff (rst)
    tick |-> rise1 || rise2)
    else $error("update without pin edge");

  en_set_a: assert property (@(posedge mclk) disable iff (rst)
    tick && bus_drive_enable != rbt_pkg::EN_ZERO |=> en_q)
    else $error("enable not set");

  bus_follow_a: assert property (@(posedge mclk) disable iff (rst)
    en_q |-> bus_out.o == tx_q)
    else $error("bus level not following transmit");

  tx_drive_a: assert property (@(posedge mclk) disable iff (rst)
    en_q |-> bus_out.oe == tx_q)
    else $error("high level not driven");

  rise1_once_a: assert property (@(posedge mclk) disable iff (rst)
    rise1 |=> !rise1)
    else $error("first clock edge counted twice");

  rise2_once_a: assert property (@(posedge mclk) disable iff (rst)
    rise2 |=> !rise2)
    else $error("second clock edge counted twice");

  filter1_hold_a: assert property (@(posedge mclk) disable iff (rst)
    c1_sync_q[1] != c1_sync_q[2] |=> $stable(clk_lvl_q[0]))
    else $error("first clock level moved while unsettled");

  filter2_hold_a: assert property (@(posedge mclk) disable iff (rst)
    c2_sync_q[1] != c2_sync_q[2] |=> $stable(clk_lvl_q[1]))
    else $error("second clock level moved while unsettled");

endmodule
`default_nettype wire

// >>> src/rbt_pkg.sv
// Purpose: Shared types and constants for the registered bus transceiver.
// Assumes: One system clock; the two device clocks arrive as pin inputs.
// Notes:   Channel count and the synchroniser depth live here.
`default_nettype none
package rbt_pkg;
  localparam int unsigned NUM_CH   = 3;
  localparam int unsigned SYNC_LEN = 3;
  localparam logic [2:0]  CH_ZERO  = 3'h0;
  localparam logic [1:0]  EN_ZERO  = 2'h0;
  localparam logic [1:0]  CLK_ZERO = 2'h0;

  typedef logic [NUM_CH-1:0] rbt_ch_t;

  // Transmit data inputs for all channels, A and B sets.
  typedef struct packed {
    rbt_ch_t a;
    rbt_ch_t b;
  } rbt_data_in_t;

  // Drive of every channel's bus pin: level and output enable.
  typedef struct packed {
    rbt_ch_t o;
    rbt_ch_t oe;
  } rbt_bus_out_t;
endpackage
`default_nettype wire

// >>> test/rbt_bus_partner.sv
// Purpose: Far side of the wired bus seen by the transceiver bench.
// Assumes: Lines that nobody drives are terminated low.
// Notes:   Another driver on the bus may pull any line high.
`default_nettype none
module rbt_bus_partner (
  // Device drive and far driver.
  input  wire rbt_pkg::rbt_bus_out_t dev,
  input  wire rbt_pkg::rbt_ch_t      far_hi,
  // Resolved bus level.
  output logic [2:0]                 line
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released device line leaves the level to the far driver.
  assign line = (dev.o & dev.oe) | far_hi;
endmodule
`default_nettype wire

// >>> test/rbt_transceiver_tb.sv
// Purpose: Self-checking bench for the registered bus transceiver.
// Assumes: Expected values are noted in a queue per device clock pulse.
// Notes:   Either or both device clocks are pulsed at random.
`default_nettype none
module rbt_transceiver_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk = 1'b0, rst = 1'b1, ck1 = 1'b0, ck2 = 1'b0;
  logic                  ld = 1'b0, selb = 1'b0, gn = 1'b1, en_m = 1'b0;
  logic [1:0]            en = 2'h0;
  rbt_pkg::rbt_data_in_t din = 6'h00;
  rbt_pkg::rbt_ch_t      far = 3'h0, line, rx, tx_m = 3'h0, rx_m = 3'h0;
  rbt_pkg::rbt_bus_out_t bo;
  logic [8:0]            q[$];
  logic [8:0]            exp_v;
  int                    failures = 0, checks = 0;
  event                  seen;

  always #4 mclk = ~mclk;

  rbt_transceiver i_rbt_transceiver (.mclk(mclk), .rst(rst),
    .first_clock_input(ck1), .second_clock_input(ck2),
    .transmit_load_enable(ld), .data_select_b(selb), .data_in(din),
    .bus_drive_enable(en), .receive_gate_n(gn), .bus_line_i(line),
    .bus_out(bo), .receive_output(rx));
  rbt_bus_partner i_rbt_bus_partner (.dev(bo), .far_hi(far), .line(line));

  task automatic stop_test;
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Pulses the chosen device clocks, then notes the expected outputs.
  task automatic pulse(input logic [1:0] which);
    repeat (3) @(negedge mclk);
    ck1 = which[0];
    ck2 = which[1];
    repeat (4) @(negedge mclk);
    ck1 = 1'b0;
    ck2 = 1'b0;
    repeat (4) @(negedge mclk);
    if (!gn) rx_m = (tx_m & {3{en_m}}) | far;
    if (ld) tx_m = selb ? din.b : din.a;
    en_m = |en;
    q.push_back({tx_m & {3{en_m}}, tx_m & {3{en_m}}, rx_m});
    -> seen;
  endtask

  always @(seen) begin
    exp_v = q.pop_front();
    checks += 2;
    if (bo !== exp_v[8:3]) begin
      failures++;
      $display("BAD bus_out exp %h got %h", exp_v[8:3], bo);
    end
    if (rx !== exp_v[2:0]) begin
      failures++;
      $display("BAD receive_output exp %h got %h", exp_v[2:0], rx);
    end
  end

  initial begin
    #20us;
    failures++;
    stop_test;
  end

  initial begin
    void'($urandom(32'hb62b17df));
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    q.push_back(9'h000);
    -> seen;
    for (int i = 0; i < 40; i++) begin
      @(negedge mclk);
      {ld, selb, gn, en, din, far} = 14'($urandom);
      pulse(2'($urandom_range(3, 1)));
    end
    stop_test;
  end
endmodule
`default_nettype wire
